// ==== verilog/srmc_ctrl.sv ====
/*
 System control registers: standby/active, data rates, auto-sleep,
 low-noise gain, fast-read burst addressing and soft reset boot.
 Assumes register strobes and sensor inputs are synchronous to i_clock.
*/
// What this block does
// - Only mode bit of system_control_one writable while active
// - Sleep rate codes give 50/12.5/6.25/1.56 Hz
// - Sleep rate overrides data rate in sleep
// - Hybrid halves the sleep rate
// - Data rate codes give 800 down to 1.5625
// - Hybrid halves the data rate
// - Low-noise doubles gain, not with 8 g
// - Low-noise clamps signal at 4 g
// - Fast-read burst skips low bytes
// - Hybrid fast-read burst reads all high bytes
// - Fast-read changes only while FIFO off
// - Mode bit resets to standby
// - Inactivity past timeout enters sleep
// - Soft reset bit cleared after boot
`timescale 1ns/1ps
`include "srmc_defs.svh"
module srmc_ctrl #(
    parameter int P_CYC_PER_US = `SRMC_CLK_MHZ,
    parameter int P_BOOT_CYC   = `SRMC_BOOT_US * `SRMC_CLK_MHZ,
    parameter int P_ONE_G      = 2048
) (
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_nrst,
    // Register port
    input  wire logic        i_reg_wr,
    input  wire logic        i_reg_rd,
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    output logic      [7:0]  o_reg_rdata,
    // System context
    input  wire logic [1:0]  i_fifo_mode,
    input  wire logic        i_hybrid,
    input  wire logic        i_hyb_autoinc,
    input  wire logic [1:0]  i_fsr,
    input  wire logic        i_wake_event,
    input  wire logic [7:0]  i_aslp_count,
    // Accelerometer sample path
    input  wire logic [15:0] i_accel_sample,
    output logic      [15:0] o_accel_sample,
    // Burst address pointer
    input  wire logic        i_burst_load,
    input  wire logic        i_burst_next,
    input  wire logic [7:0]  i_burst_addr,
    output logic      [7:0]  o_burst_addr,
    // Mode outputs
    output logic             o_active,
    output logic             o_sleeping,
    output logic             o_booting,
    output logic             o_odr_tick,
    output logic             o_gain_x2,
    output logic             o_fast_read,
    output logic             o_self_test_en
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (P_CYC_PER_US < 1 || P_BOOT_CYC < 1 || P_ONE_G < 1 ||
        P_ONE_G > 8191) begin : g_bad
        $error("srmc_ctrl: parameter out of range");
    end

    localparam logic signed [15:0] LIM =
        16'(`SRMC_LNOISE_G * P_ONE_G);

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [31:0] period_us(input logic [2:0] c);
        case (c)
            3'h0:    period_us = `SRMC_PER_US_0;
            3'h1:    period_us = `SRMC_PER_US_1;
            3'h2:    period_us = `SRMC_PER_US_2;
            3'h3:    period_us = `SRMC_PER_US_3;
            3'h4:    period_us = `SRMC_PER_US_4;
            3'h5:    period_us = `SRMC_PER_US_5;
            3'h6:    period_us = `SRMC_PER_US_6;
            default: period_us = `SRMC_PER_US_7;
        endcase
    endfunction

    function automatic logic in_data(input logic [7:0] a);
        in_data = (a >= `SRMC_ACC_X_MSB && a <= `SRMC_ACC_Z_LSB) ||
                  (a >= `SRMC_MAG_X_MSB && a <= `SRMC_MAG_Z_LSB);
    endfunction

    function automatic logic [7:0] next_addr(input logic [7:0] a,
                                             input logic       fr,
                                             input logic       hy);
        if (hy && (a == `SRMC_ACC_Z_LSB || (fr && a == `SRMC_ACC_Z_MSB)))
            next_addr = `SRMC_MAG_X_MSB;
        else if (hy && (a == `SRMC_MAG_Z_LSB ||
                        (fr && a == `SRMC_MAG_Z_MSB)))
            next_addr = `SRMC_ACC_X_MSB;
        else if (fr && in_data(a))
            next_addr = a + 8'h02;
        else
            next_addr = a + 8'h01;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0]          ctrl_one_r;
    logic [7:0]          ctrl_two_r;
    logic [31:0]         boot_cnt_r;
    logic                booting_r;
    logic                boot_done;
    logic                wr_one;
    logic                wr_two;
    logic [7:0]          ctrl_one_nxt;
    srmc_pkg::srmc_power_e power_r;
    logic [8:0]          idle_cnt_r;
    logic [2:0]          rate_code;
    logic [31:0]         period_cyc;
    logic                tick;

    assign wr_one    = i_reg_wr && !booting_r &&
                       i_reg_addr == `SRMC_ADDR_CTRL_ONE;
    assign wr_two    = i_reg_wr && !booting_r &&
                       i_reg_addr == `SRMC_ADDR_CTRL_TWO;
    assign boot_done = booting_r && boot_cnt_r == 32'(P_BOOT_CYC - 1);

    // ------------------------------------------------------------
    // Control one write filter
    // ------------------------------------------------------------
    always_comb begin
        ctrl_one_nxt = ctrl_one_r;
        if (!ctrl_one_r[`SRMC_ACTIVE_BIT]) begin
            ctrl_one_nxt = i_reg_wdata;
            if (i_fifo_mode != 2'b00)
                ctrl_one_nxt[`SRMC_FREAD_BIT] =
                    ctrl_one_r[`SRMC_FREAD_BIT];
        end else begin
            // Active: protected fields keep their values
            ctrl_one_nxt[`SRMC_ACTIVE_BIT] =
                i_reg_wdata[`SRMC_ACTIVE_BIT];
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst)
            ctrl_one_r <= `SRMC_CTRL_ONE_RST;
        else if (boot_done)
            ctrl_one_r <= `SRMC_CTRL_ONE_RST;
        else if (booting_r)
            ctrl_one_r[`SRMC_ACTIVE_BIT] <= 1'b0;
        else if (wr_one)
            ctrl_one_r <= ctrl_one_nxt;
    end

    // ------------------------------------------------------------
    // Control two and soft reset boot
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst)
            ctrl_two_r <= `SRMC_CTRL_TWO_RST;
        else if (boot_done)
            ctrl_two_r <= `SRMC_CTRL_TWO_RST;
        else if (wr_two)
            ctrl_two_r <= i_reg_wdata & `SRMC_CTRL_TWO_MASK;
    end

    // Register port ignores writes during boot, as the link is reset too
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            booting_r  <= 1'b0;
            boot_cnt_r <= '0;
        end else if (boot_done) begin
            booting_r  <= 1'b0;
            boot_cnt_r <= '0;
        end else if (booting_r) begin
            boot_cnt_r <= boot_cnt_r + 32'h1;
        end else if (wr_two && i_reg_wdata[`SRMC_RST_BIT]) begin
            booting_r  <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst)
            o_reg_rdata <= 8'h00;
        else if (i_reg_rd) begin
            case (i_reg_addr)
                `SRMC_ADDR_CTRL_ONE: o_reg_rdata <= ctrl_one_r;
                `SRMC_ADDR_CTRL_TWO: o_reg_rdata <= ctrl_two_r;
                default:             o_reg_rdata <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Power state and auto-sleep timer
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            power_r    <= srmc_pkg::SRMC_STANDBY;
            idle_cnt_r <= '0;
        end else begin
            case (power_r)
                srmc_pkg::SRMC_STANDBY: begin
                    idle_cnt_r <= '0;
                    if (ctrl_one_r[`SRMC_ACTIVE_BIT])
                        power_r <= srmc_pkg::SRMC_WAKE;
                end
                srmc_pkg::SRMC_WAKE: begin
                    if (!ctrl_one_r[`SRMC_ACTIVE_BIT])
                        power_r <= srmc_pkg::SRMC_STANDBY;
                    else if (i_wake_event || !ctrl_two_r[`SRMC_SLPE_BIT])
                        idle_cnt_r <= '0;
                    else if (idle_cnt_r > {1'b0, i_aslp_count}) begin
                        power_r    <= srmc_pkg::SRMC_SLEEP;
                        idle_cnt_r <= '0;
                    end else if (tick)
                        idle_cnt_r <= idle_cnt_r + 9'h1;
                end
                srmc_pkg::SRMC_SLEEP: begin
                    if (!ctrl_one_r[`SRMC_ACTIVE_BIT])
                        power_r <= srmc_pkg::SRMC_STANDBY;
                    else if (i_wake_event || !ctrl_two_r[`SRMC_SLPE_BIT])
                        power_r <= srmc_pkg::SRMC_WAKE;
                end
                default: power_r <= srmc_pkg::SRMC_STANDBY;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Effective data rate
    // ------------------------------------------------------------
    // Sleep codes 00..11 share the periods of data rate codes 100..111
    assign rate_code = (power_r == srmc_pkg::SRMC_SLEEP) ?
        {1'b1, ctrl_one_r[`SRMC_ASLP_MSB:`SRMC_ASLP_LSB]} :
        ctrl_one_r[`SRMC_ODR_MSB:`SRMC_ODR_LSB];
    // Hybrid doubles the period, halving the rate
    assign period_cyc = (period_us(rate_code) * 32'(P_CYC_PER_US))
                        << i_hybrid;

    srmc_rate_gen #(
        .W (32)
    ) srmc_rate_gen_inst (
        .i_clock  (i_clock),
        .i_nrst   (i_nrst),
        .i_run    (power_r != srmc_pkg::SRMC_STANDBY),
        .i_period (period_cyc),
        .o_tick   (tick)
    );

    // ------------------------------------------------------------
    // Low-noise clamp
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst)
            o_accel_sample <= 16'h0000;
        else if (ctrl_one_r[`SRMC_LNOISE_BIT] &&
                 $signed(i_accel_sample) > LIM)
            o_accel_sample <= LIM;
        else if (ctrl_one_r[`SRMC_LNOISE_BIT] &&
                 $signed(i_accel_sample) < -LIM)
            o_accel_sample <= -LIM;
        else
            o_accel_sample <= i_accel_sample;
    end

    // ------------------------------------------------------------
    // Burst address pointer
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst)
            o_burst_addr <= 8'h00;
        else if (i_burst_load)
            o_burst_addr <= i_burst_addr;
        else if (i_burst_next)
            o_burst_addr <= next_addr(o_burst_addr,
                                      ctrl_one_r[`SRMC_FREAD_BIT],
                                      i_hybrid && i_hyb_autoinc);
    end

    // ------------------------------------------------------------
    // Mode outputs
    // ------------------------------------------------------------
    assign o_active       = ctrl_one_r[`SRMC_ACTIVE_BIT];
    assign o_sleeping     = power_r == srmc_pkg::SRMC_SLEEP;
    assign o_booting      = booting_r;
    assign o_odr_tick     = tick;
    // Gain held at unity if 8 g is selected anyway
    assign o_gain_x2      = ctrl_one_r[`SRMC_LNOISE_BIT] &&
                            i_fsr != `SRMC_FSR_8G;
    assign o_fast_read    = ctrl_one_r[`SRMC_FREAD_BIT];
    assign o_self_test_en = ctrl_two_r[`SRMC_SELF_TEST_BIT];
endmodule // srmc_ctrl

// ==== verilog/srmc_defs.svh ====
/*
 Offsets, field positions, reset values and timing figures of the
 rate and mode control block. Assumes it is included by bare name.
*/
`ifndef SRMC_DEFS_SVH
`define SRMC_DEFS_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define SRMC_ADDR_CTRL_ONE   8'h2a
`define SRMC_ADDR_CTRL_TWO   8'h2b

// ------------------------------------------------------------
// Reset values and control two write mask
// ------------------------------------------------------------
`define SRMC_CTRL_ONE_RST    8'h08
`define SRMC_CTRL_TWO_RST    8'h00
`define SRMC_CTRL_TWO_MASK   8'hdf

// ------------------------------------------------------------
// Field positions, system_control_one
// ------------------------------------------------------------
`define SRMC_ACTIVE_BIT      0
`define SRMC_FREAD_BIT       1
`define SRMC_LNOISE_BIT      2
`define SRMC_ODR_LSB         3
`define SRMC_ODR_MSB         5
`define SRMC_ASLP_LSB        6
`define SRMC_ASLP_MSB        7

// ------------------------------------------------------------
// Field positions, system_control_two
// ------------------------------------------------------------
`define SRMC_SLPE_BIT        2
`define SRMC_RST_BIT         6
`define SRMC_SELF_TEST_BIT   7

// ------------------------------------------------------------
// Output data addresses for burst reads
// ------------------------------------------------------------
`define SRMC_ACC_X_MSB       8'h01
`define SRMC_ACC_Z_MSB       8'h05
`define SRMC_ACC_Z_LSB       8'h06
`define SRMC_MAG_X_MSB       8'h33
`define SRMC_MAG_Z_MSB       8'h37
`define SRMC_MAG_Z_LSB       8'h38

// ------------------------------------------------------------
// Clock, boot time, periods in microseconds per data rate code, 8 g range code, clamp in g
// ------------------------------------------------------------
`define SRMC_CLK_MHZ         20
`define SRMC_PER_US_0        32'd1250
`define SRMC_PER_US_1        32'd2500
`define SRMC_PER_US_2        32'd5000
`define SRMC_PER_US_3        32'd10000
`define SRMC_PER_US_4        32'd20000
`define SRMC_PER_US_5        32'd80000
`define SRMC_PER_US_6        32'd160000
`define SRMC_PER_US_7        32'd640000
`define SRMC_BOOT_US         1000
`define SRMC_FSR_8G          2'b10
`define SRMC_LNOISE_G        4

`endif

// ==== verilog/srmc_pkg.sv ====
/*
 Types of the rate and mode control block.
 Assumes srmc_defs.svh carries the numbers.
*/
package srmc_pkg;
    typedef enum logic [1:0] {
        SRMC_STANDBY,
        SRMC_WAKE,
        SRMC_SLEEP
    } srmc_power_e;
endpackage

// ==== verilog/srmc_rate_gen.sv ====
/*
 Data rate tick divider: one-cycle enable every i_period cycles.
 Assumes i_period is at least 1 and steady while running.
*/
`timescale 1ns/1ps
module srmc_rate_gen #(
    parameter int W = 32
) (
    // Clock and reset
    input  wire logic         i_clock,
    input  wire logic         i_nrst,
    // Control
    input  wire logic         i_run,
    input  wire logic [W-1:0] i_period,
    // Tick
    output logic              o_tick
);
    logic [W-1:0] cnt_r;

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_r  <= '0;
            o_tick <= 1'b0;
        end else if (!i_run) begin
            cnt_r  <= '0;
            o_tick <= 1'b0;
        end else if (cnt_r >= i_period - W'(1)) begin
            // >= so a shorter new period never overruns
            cnt_r  <= '0;
            o_tick <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + W'(1);
            o_tick <= 1'b0;
        end
    end
endmodule // srmc_rate_gen

// ==== dv/srmc_ctrl_asserts.sv ====
/*
 Checker for the rate and mode control block ports.
 Assumes a bind onto srmc_ctrl and srmc_defs.svh on the include path.
*/
`timescale 1ns/1ps
`include "srmc_defs.svh"
module srmc_ctrl_chk #(
    parameter int P_ONE_G = 2048
) (
    // Clock and reset
    input wire logic        i_clock,
    input wire logic        i_nrst,
    // Register port
    input wire logic        i_reg_wr,
    input wire logic [7:0]  i_reg_addr,
    input wire logic [7:0]  i_reg_wdata,
    // Context
    input wire logic [1:0]  i_fifo_mode,
    input wire logic        i_hybrid,
    input wire logic        i_hyb_autoinc,
    input wire logic [1:0]  i_fsr,
    input wire logic [15:0] i_accel_sample,
    input wire logic        i_burst_load,
    input wire logic        i_burst_next,
    // Outputs watched
    input wire logic [15:0] o_accel_sample,
    input wire logic [7:0]  o_burst_addr,
    input wire logic        o_active,
    input wire logic        o_sleeping,
    input wire logic        o_booting,
    input wire logic        o_odr_tick,
    input wire logic        o_gain_x2,
    input wire logic        o_fast_read
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    // Boot writes excluded from w1 only: the boot sequence owns the registers then
    wire w1 = i_reg_wr && i_reg_addr == `SRMC_ADDR_CTRL_ONE && !o_booting;
    wire w2 = i_reg_wr && i_reg_addr == `SRMC_ADDR_CTRL_TWO;
    wire fr_step = i_burst_next && !i_burst_load && o_fast_read;

    AST_MODE_ANY: assert property (w1 |=> o_active == $past(i_reg_wdata[0]))
        else $error("mode bit not taken");
    AST_PROT_KEEP: assert property (w1 && o_active |=> $stable(o_fast_read))
        else $error("protected field changed while active");
    AST_FREAD_FIFO: assert property (!o_booting && !w2 && i_fifo_mode != 2'b00
        |=> $stable(o_fast_read)) else $error("fast-read changed with fifo on");
    AST_GAIN_8G: assert property (i_fsr == `SRMC_FSR_8G |-> !o_gain_x2)
        else $error("gain doubled in 8 g range");
    AST_CLAMP: assert property (o_gain_x2 && $signed(i_accel_sample) > 4*P_ONE_G
        |=> o_accel_sample == 16'(4*P_ONE_G)) else $error("no clamp");
    AST_PASS: assert property (!o_gain_x2 && i_fsr != `SRMC_FSR_8G
        |=> o_accel_sample == $past(i_accel_sample)) else $error("bad pass");
    AST_FAST_SKIP: assert property (fr_step && o_burst_addr inside {[8'h01:8'h04]}
        |=> o_burst_addr == $past(o_burst_addr) + 8'h02) else $error("no skip");
    AST_HYB_WRAP: assert property (fr_step && i_hybrid && i_hyb_autoinc
        && o_burst_addr == `SRMC_ACC_Z_MSB |=> o_burst_addr == `SRMC_MAG_X_MSB)
        else $error("no wrap to magnetometer");
    AST_BOOT: assert property ($rose(o_booting) |=> !o_active
        && o_booting ##1 o_booting [*3] ##[1:12] !o_booting)
        else $error("boot length");
    AST_QUIET: assert property (!o_active [*4] |-> !o_odr_tick)
        else $error("tick in standby");

    cover property ($rose(o_sleeping));
    cover property ($rose(o_booting));
    cover property (fr_step && i_hybrid && o_burst_addr == `SRMC_ACC_Z_MSB);
endmodule // srmc_ctrl_chk

bind srmc_ctrl srmc_ctrl_chk #(.P_ONE_G(P_ONE_G)) srmc_ctrl_chk_inst (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_reg_wr(i_reg_wr),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_fifo_mode(i_fifo_mode), .i_hybrid(i_hybrid),
    .i_hyb_autoinc(i_hyb_autoinc), .i_fsr(i_fsr),
    .i_accel_sample(i_accel_sample), .i_burst_load(i_burst_load),
    .i_burst_next(i_burst_next), .o_accel_sample(o_accel_sample),
    .o_burst_addr(o_burst_addr), .o_active(o_active),
    .o_sleeping(o_sleeping), .o_booting(o_booting),
    .o_odr_tick(o_odr_tick), .o_gain_x2(o_gain_x2),
    .o_fast_read(o_fast_read));

// ==== dv/sensor_rate_mode_control_tb_top.sv ====
/*
 Self-checking bench of the rate and mode control block.
 Assumes short counts: one cycle per microsecond, boot of 8 cycles.
*/
`timescale 1ns/1ps
module sensor_rate_mode_control_tb_top;
    logic        clk = 0, nrst = 0, wr = 0, rd = 0, wake = 0;
    logic [7:0]  addr = 0, wdat = 0, baddr = 0, acnt = 8'h02, rdat, bout;
    logic [1:0]  fifo = 0, fsr = 0;
    logic        hyb = 0, hinc = 0, bload = 0, bnext = 0;
    logic [15:0] smp = 0, sout;
    logic        act, slp, boot, tick, gx2, fr, ste;
    int          err_count = 0, total_checks = 0, cyc = 0, tcnt = 0;
    logic [15:0] rq[$];
    int          tq[$];
    bit          arm = 0, seen = 0;
    logic [7:0]  d;
    int          s;

    srmc_ctrl #(.P_CYC_PER_US(1), .P_BOOT_CYC(8)) srmc_ctrl_inst (
        .i_clock(clk), .i_nrst(nrst), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wdat), .o_reg_rdata(rdat),
        .i_fifo_mode(fifo), .i_hybrid(hyb), .i_hyb_autoinc(hinc),
        .i_fsr(fsr), .i_wake_event(wake), .i_aslp_count(acnt),
        .i_accel_sample(smp), .o_accel_sample(sout),
        .i_burst_load(bload), .i_burst_next(bnext), .i_burst_addr(baddr),
        .o_burst_addr(bout), .o_active(act), .o_sleeping(slp),
        .o_booting(boot), .o_odr_tick(tick), .o_gain_x2(gx2),
        .o_fast_read(fr), .o_self_test_en(ste));

    initial begin
        forever #25 clk = ~clk;
    end

    task automatic chk(input logic [15:0] g, e);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wreg(input logic [7:0] a, v);
        @(negedge clk);
        wr = 1;
        addr = a;
        wdat = v;
        @(negedge clk);
        wr = 0;
    endtask

    // Expected value noted before the strobe; monitor pops it
    task automatic rreg(input logic [7:0] a, e);
        @(negedge clk);
        rd = 1;
        addr = a;
        rq.push_back({8'h00, e});
        @(negedge clk);
        rd = 0;
        @(negedge clk);
    endtask

    task automatic period(input int p);
        int n = 0;
        tq.push_back(p);
        seen = 0;
        arm = 1;
        while (arm && n < 3 * p) begin
            @(negedge clk);
            n++;
        end
        if (arm) begin
            err_count++;
            arm = 0;
            tq.delete();
        end
    endtask

    // Burst inputs held between steps so no signal toggles twice at once
    task automatic bstep(input logic l, input logic [7:0] a, e);
        bload = l;
        bnext = !l;
        baddr = a;
        @(negedge clk);
        chk(bout, e);
    endtask

    always @(posedge clk) begin
        if (rd) begin
            @(negedge clk);
            chk(rdat, rq.pop_front());
        end
    end

    // Tick spacing measured between two ticks after arming
    always @(negedge clk) begin
        cyc++;
        tcnt++;
        if (cyc == 99000) begin
            err_count++;
            end_of_test();
        end
        if (tick && arm) begin
            if (seen) begin
                chk(16'(tcnt), 16'(tq.pop_front()));
                arm = 0;
            end
            seen = 1;
            tcnt = 0;
        end
    end

    initial begin
        repeat (3) @(negedge clk);
        nrst = 1;
        void'($urandom(15248));
        rreg(8'h2a, 8'h08);
        rreg(8'h2b, 8'h00);
        rreg(8'h2c, 8'h00);
        d = 8'($urandom) & 8'hfe;
        wreg(8'h2a, d);
        rreg(8'h2a, d);
        wreg(8'h2b, 8'ha0);
        chk(ste, 1'b1);
        rreg(8'h2b, 8'h80);
        wreg(8'h2b, 8'h00);
        $display("test registers done");
        wreg(8'h2a, 8'h19);
        rreg(8'h2a, 8'h19);
        wreg(8'h2a, 8'he7);
        rreg(8'h2a, 8'h19);
        wreg(8'h2a, 8'h18);
        rreg(8'h2a, 8'h18);
        fifo = 2'b01;
        wreg(8'h2a, 8'h0a);
        rreg(8'h2a, 8'h08);
        fifo = 2'b00;
        wreg(8'h2a, 8'h0a);
        rreg(8'h2a, 8'h0a);
        chk(fr, 1'b1);
        $display("test protection done");
        for (int c = 0; c < 4; c++) begin
            hyb = (c == 3);
            wreg(8'h2a, 8'((c % 3) << 3));
            wreg(8'h2a, 8'((c % 3) << 3) | 8'h01);
            period((1250 << (c % 3)) * (hyb ? 2 : 1));
        end
        hyb = 0;
        wreg(8'h2a, 8'h00);
        $display("test rates done");
        wreg(8'h2b, 8'h04);
        wreg(8'h2a, 8'h01);
        for (int n = 0; n < 8000 && !slp; n++) @(negedge clk);
        chk(slp, 1'b1);
        period(20000);
        wake = 1;
        repeat (3) @(negedge clk);
        wake = 0;
        chk(slp, 1'b0);
        wreg(8'h2a, 8'h00);
        wreg(8'h2b, 8'h00);
        $display("test sleep done");
        wreg(8'h2a, 8'h0c);
        chk(gx2, 1'b1);
        for (int n = 0; n < 8; n++) begin
            smp = 16'($urandom);
            s = $signed(smp);
            @(negedge clk);
            chk(sout, 16'(s > 8192 ? 8192 : s < -8192 ? -8192 : s));
        end
        fsr = 2'b10;
        @(negedge clk);
        chk(gx2, 1'b0);
        $display("test low noise done");
        wreg(8'h2a, 8'h0a);
        hyb = 1;
        hinc = 1;
        bstep(1, 8'h01, 8'h01);
        bstep(0, 8'h00, 8'h03);
        bstep(0, 8'h00, 8'h05);
        bstep(0, 8'h00, 8'h33);
        bstep(0, 8'h00, 8'h35);
        bstep(0, 8'h00, 8'h37);
        bstep(0, 8'h00, 8'h01);
        wreg(8'h2a, 8'h08);
        bstep(1, 8'h05, 8'h05);
        bstep(0, 8'h00, 8'h06);
        bstep(0, 8'h00, 8'h33);
        bnext = 0;
        $display("test burst done");
        wreg(8'h2a, 8'h19);
        wreg(8'h2b, 8'h40);
        chk(boot, 1'b1);
        // Mode bit drops one cycle after boot starts
        @(negedge clk);
        chk(act, 1'b0);
        wreg(8'h2a, 8'h11);
        for (int n = 0; n < 20 && boot; n++) @(negedge clk);
        rreg(8'h2a, 8'h08);
        rreg(8'h2b, 8'h00);
        $display("test soft reset done");
        end_of_test();
    end
endmodule // sensor_rate_mode_control_tb_top
